// >>> logic/cise_pkg.sv
// Constants for the instruction subset execute core
package cise_pkg;
    localparam int ACC_W = 8;
    localparam int PC_W = 12;
    localparam int FA_W = 7;
    localparam int SR_W = 6;
    localparam int OP_W = 14;
    localparam int STK_DEPTH = 8;
    localparam int STK_PTR_W = 3;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [11:0] PC_RESET = 12'h000;
    localparam logic [5:0] OP_DEC = 6'h03;
    localparam logic [5:0] OP_DECSZ = 6'h0b;
    localparam logic [5:0] OP_INC = 6'h0a;
    localparam logic [5:0] OP_INCSZ = 6'h0f;
    localparam logic [5:0] OP_ORF = 6'h04;
    localparam logic [5:0] OP_MOVF = 6'h08;
    localparam logic [5:0] OP_ORL = 6'h1a;
    localparam logic [5:0] OP_MOVL = 6'h19;
    localparam logic [5:0] OP_SYS = 6'h00;
    localparam logic [1:0] OP_JUMP = 2'h3;
    localparam logic [1:0] OP_CALL = 2'h2;
    localparam logic [13:0] OP_NOP = 14'h0000;
    localparam logic [13:0] OP_RET = 14'h0040;
    localparam logic [13:0] OP_INTERRUPT_RETURN = 14'h0060;
    localparam int DEST_BIT = 7;
    localparam int STORE_BIT = 7;
endpackage

// >>> logic/cise_core.sv
// Decode and execute core for the instruction subset
`timescale 1ns/1ps
`default_nettype none
module cise_core (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic [13:0] i_instr,
    input wire logic [7:0] i_file_rdata,
    output logic [11:0] o_program_counter,
    output logic [6:0] o_file_addr,
    output logic [7:0] o_file_wdata,
    output logic o_file_we,
    output logic [5:0] o_special_addr,
    output logic [7:0] o_special_wdata,
    output logic o_special_we,
    output logic [7:0] o_acc,
    output logic o_zero_flag,
    output logic o_global_irq_enable
);
    // Two-cycle instructions flush the fetched word in the second cycle
    logic [11:0] pc_reg, pc_next;
    logic [7:0] acc_reg, acc_next;
    logic zero_reg, zero_next;
    logic gie_reg, gie_next;
    logic flush_reg, flush_next;
    // Set for branches: the flushed cycle keeps pc on the target word
    logic hold_reg, hold_next;
    logic [2:0] sp_reg, sp_next;
    logic [11:0] stack_reg [cise_pkg::STK_DEPTH];
    logic push;
    logic [11:0] top_entry;
    logic [6:0] fa_reg, fa_next;
    logic [7:0] fw_reg, fw_next;
    logic fwe_reg, fwe_next;
    logic [5:0] sa_reg, sa_next;
    logic swe_reg, swe_next;

    logic [5:0] op6;
    logic [6:0] faddr;
    logic [7:0] lit;
    logic dest;
    logic [7:0] res;
    logic route;

    assign op6 = i_instr[13:8];
    assign faddr = i_instr[6:0];
    assign lit = i_instr[7:0];
    assign dest = i_instr[cise_pkg::DEST_BIT];
    assign top_entry = stack_reg[sp_reg - 3'h1];

    always_comb begin
        pc_next = pc_reg + 12'h001;
        acc_next = acc_reg;
        zero_next = zero_reg;
        gie_next = gie_reg;
        flush_next = 1'b0;
        hold_next = 1'b0;
        sp_next = sp_reg;
        push = 1'b0;
        fa_next = faddr;
        fw_next = fw_reg;
        fwe_next = 1'b0;
        sa_next = sa_reg;
        swe_next = 1'b0;
        res = 8'h00;
        route = 1'b0;
        if (flush_reg) begin
            // Discarded word executes as a no-op
            if (hold_reg) begin
                // Target word is fetched again, so it is not lost
                pc_next = pc_reg;
            end
        end else if (i_instr[13:12] == cise_pkg::OP_JUMP) begin
            pc_next = i_instr[11:0];
            flush_next = 1'b1;
            hold_next = 1'b1;
        end else if (i_instr[13:12] == cise_pkg::OP_CALL) begin
            push = 1'b1;
            sp_next = sp_reg + 3'h1;
            pc_next = i_instr[11:0];
            flush_next = 1'b1;
            hold_next = 1'b1;
        end else begin
            unique case (op6)
                cise_pkg::OP_DEC: begin
                    res = i_file_rdata - 8'h01;
                    zero_next = (res == 8'h00);
                    route = 1'b1;
                end
                cise_pkg::OP_DECSZ: begin
                    res = i_file_rdata - 8'h01;
                    route = 1'b1;
                    flush_next = (res == 8'h00);
                end
                cise_pkg::OP_INC: begin
                    res = i_file_rdata + 8'h01;
                    zero_next = (res == 8'h00);
                    route = 1'b1;
                end
                cise_pkg::OP_INCSZ: begin
                    res = i_file_rdata + 8'h01;
                    route = 1'b1;
                    flush_next = (res == 8'h00);
                end
                cise_pkg::OP_ORF: begin
                    res = acc_reg | i_file_rdata;
                    zero_next = (res == 8'h00);
                    route = 1'b1;
                end
                cise_pkg::OP_MOVF: begin
                    if (!i_instr[cise_pkg::STORE_BIT]) begin
                        acc_next = i_file_rdata;
                    end
                end
                cise_pkg::OP_ORL: begin
                    acc_next = acc_reg | lit;
                    zero_next = ((acc_reg | lit) == 8'h00);
                end
                cise_pkg::OP_MOVL: begin
                    acc_next = lit;
                end
                cise_pkg::OP_SYS: begin
                    if (i_instr[cise_pkg::STORE_BIT]) begin
                        fw_next = acc_reg;
                        fwe_next = 1'b1;
                    end else if (i_instr == cise_pkg::OP_RET) begin
                        sp_next = sp_reg - 3'h1;
                        pc_next = top_entry;
                        flush_next = 1'b1;
                        hold_next = 1'b1;
                    end else if (i_instr == cise_pkg::OP_INTERRUPT_RETURN) begin
                        sp_next = sp_reg - 3'h1;
                        pc_next = top_entry;
                        gie_next = 1'b1;
                        flush_next = 1'b1;
                        hold_next = 1'b1;
                    end else if (i_instr == cise_pkg::OP_NOP) begin
                        // Idle cycle
                    end else if (i_instr[7:6] == 2'h0) begin
                        sa_next = i_instr[5:0];
                        fw_next = acc_reg;
                        swe_next = 1'b1;
                    end
                end
                default: begin
                    // Opcodes outside this subset advance only
                end
            endcase
            if (route) begin
                if (dest) begin
                    fw_next = res;
                    fwe_next = 1'b1;
                end else begin
                    acc_next = res;
                end
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            pc_reg <= cise_pkg::PC_RESET;
            acc_reg <= cise_pkg::ACC_RESET;
            zero_reg <= 1'b0;
            gie_reg <= 1'b0;
            flush_reg <= 1'b0;
            hold_reg <= 1'b0;
            sp_reg <= 3'h0;
            fa_reg <= 7'h00;
            fw_reg <= 8'h00;
            fwe_reg <= 1'b0;
            sa_reg <= 6'h00;
            swe_reg <= 1'b0;
        end else begin
            pc_reg <= pc_next;
            acc_reg <= acc_next;
            zero_reg <= zero_next;
            gie_reg <= gie_next;
            flush_reg <= flush_next;
            hold_reg <= hold_next;
            sp_reg <= sp_next;
            fa_reg <= fa_next;
            fw_reg <= fw_next;
            fwe_reg <= fwe_next;
            sa_reg <= sa_next;
            swe_reg <= swe_next;
        end
    end

    // Stack wraps silently when overfilled, as on the small cores
    always_ff @(posedge i_clk) begin
        if (push) begin
            stack_reg[sp_reg] <= pc_reg + 12'h001;
        end
    end

    assign o_program_counter = pc_reg;
    assign o_file_addr = fa_reg;
    assign o_file_wdata = fw_reg;
    assign o_file_we = fwe_reg;
    assign o_special_addr = sa_reg;
    assign o_special_wdata = fw_reg;
    assign o_special_we = swe_reg;
    assign o_acc = acc_reg;
    assign o_zero_flag = zero_reg;
    assign o_global_irq_enable = gie_reg;

    wire exe = !flush_reg;

    chk_jump_target: assert property (@(posedge i_clk) disable iff (i_reset)
        exe && i_instr[13:12] == 2'h3 |=> flush_reg
        && pc_reg == $past(i_instr[11:0]) ##1 $stable(pc_reg))
        else $error("jump target or flush wrong");
    chk_dec_zero: assert property (@(posedge i_clk) disable iff (i_reset)
        exe && op6 == 6'h03 |=> zero_reg == ($past(i_file_rdata) == 8'h01))
        else $error("decrement zero flag wrong");
    chk_skip_flags: assert property (@(posedge i_clk) disable iff (i_reset)
        exe && (op6 == 6'h0b || op6 == 6'h0f) |=> $stable(zero_reg))
        else $error("skip instruction changed flag");
    chk_skip_flush: assert property (@(posedge i_clk) disable iff (i_reset)
        exe && op6 == 6'h0f && i_file_rdata == 8'hff |=> flush_reg)
        else $error("increment skip did not skip");
    chk_inc_route: assert property (@(posedge i_clk) disable iff (i_reset)
        exe && op6 == 6'h0a && i_instr[7] |=> o_file_we
        && o_file_wdata == $past(i_file_rdata) + 8'h01)
        else $error("increment write-back wrong");
    chk_orl_acc: assert property (@(posedge i_clk) disable iff (i_reset)
        exe && op6 == 6'h1a |=> acc_reg == ($past(acc_reg) | $past(lit)))
        else $error("or literal wrong");
    chk_movl_acc: assert property (@(posedge i_clk) disable iff (i_reset)
        exe && op6 == 6'h19 |=> acc_reg == $past(lit) && $stable(zero_reg))
        else $error("load literal wrong");
    chk_interrupt_return_gie: assert property (@(posedge i_clk) disable iff (i_reset)
        exe && i_instr == 14'h0060 |=> gie_reg && flush_reg)
        else $error("interrupt return wrong");
    chk_call_ret: assert property (@(posedge i_clk) disable iff (i_reset)
        exe && i_instr[13:12] == 2'h2 ##2 exe && i_instr == 14'h0040
        |=> pc_reg == $past(pc_reg, 3) + 12'h001)
        else $error("return address wrong");
    cov_jump: cover property (@(posedge i_clk) exe && i_instr[13:12] == 2'h3);
    cov_skip: cover property (@(posedge i_clk) exe && op6 == 6'h0b
        ##1 flush_reg);
    cov_ret: cover property (@(posedge i_clk) exe && i_instr == 14'h0040);
    cov_interrupt_return: cover property (@(posedge i_clk) exe && i_instr == 14'h0060);
    cov_inc_skip: cover property (@(posedge i_clk) exe && op6 == 6'h0f
        ##1 flush_reg);

    // Result routing, write-back, skip, flag and flow checks
    chk_route_acc: assert property (@(posedge i_clk) disable iff (i_reset)
        exe && op6 == 6'h03 && !i_instr[7]
        |=> acc_reg == $past(i_file_rdata) - 8'h01 && !fwe_reg)
        else $error("decrement to accumulator wrong");
    chk_route_file: assert property (@(posedge i_clk) disable iff (i_reset)
        exe && op6 == 6'h04 && i_instr[7] |=> fwe_reg
        && fw_reg == ($past(acc_reg) | $past(i_file_rdata))
        && $stable(acc_reg))
        else $error("or to file wrong");
    chk_write_addr: assert property (@(posedge i_clk) disable iff (i_reset)
        fwe_reg |-> fa_reg == $past(i_instr[6:0]))
        else $error("write address wrong");
    chk_decsz_skip: assert property (@(posedge i_clk) disable iff (i_reset)
        exe && op6 == 6'h0b && i_file_rdata == 8'h01
        |=> flush_reg && !hold_reg)
        else $error("decrement skip did not skip");
    chk_decsz_keep: assert property (@(posedge i_clk) disable iff (i_reset)
        exe && op6 == 6'h0b && i_file_rdata != 8'h01 |=> !flush_reg)
        else $error("decrement skip skipped wrongly");
    chk_decsz_route: assert property (@(posedge i_clk) disable iff (i_reset)
        exe && op6 == 6'h0b && i_instr[7] |=> fwe_reg
        && fw_reg == $past(i_file_rdata) - 8'h01)
        else $error("decrement skip write-back wrong");
    chk_flush_idle: assert property (@(posedge i_clk) disable iff (i_reset)
        flush_reg |=> $stable(acc_reg) && !fwe_reg && !swe_reg)
        else $error("discarded word had an effect");
    chk_jump_flags: assert property (@(posedge i_clk) disable iff (i_reset)
        exe && i_instr[13:12] == 2'h3 |=> $stable(zero_reg)
        && $stable(acc_reg))
        else $error("jump changed state");
    chk_inc_zero: assert property (@(posedge i_clk) disable iff (i_reset)
        exe && op6 == 6'h0a |=> zero_reg == ($past(i_file_rdata) == 8'hff))
        else $error("increment zero flag wrong");
    chk_incsz_keep: assert property (@(posedge i_clk) disable iff (i_reset)
        exe && op6 == 6'h0f && i_file_rdata != 8'hff |=> !flush_reg)
        else $error("increment skip skipped wrongly");
    chk_incsz_route: assert property (@(posedge i_clk) disable iff (i_reset)
        exe && op6 == 6'h0f && !i_instr[7]
        |=> acc_reg == $past(i_file_rdata) + 8'h01)
        else $error("increment skip result wrong");
    chk_orl_zero: assert property (@(posedge i_clk) disable iff (i_reset)
        exe && op6 == 6'h1a
        |=> zero_reg == (($past(acc_reg) | $past(lit)) == 8'h00))
        else $error("or literal zero flag wrong");
    chk_orf_zero: assert property (@(posedge i_clk) disable iff (i_reset)
        exe && op6 == 6'h04
        |=> zero_reg == (($past(acc_reg) | $past(i_file_rdata)) == 8'h00))
        else $error("or file zero flag wrong");
    chk_movf_acc: assert property (@(posedge i_clk) disable iff (i_reset)
        exe && op6 == 6'h08 && !i_instr[7]
        |=> acc_reg == $past(i_file_rdata) && $stable(zero_reg))
        else $error("load file wrong");
    chk_store_file: assert property (@(posedge i_clk) disable iff (i_reset)
        exe && op6 == 6'h00 && i_instr[7]
        |=> fwe_reg && fw_reg == $past(acc_reg))
        else $error("store to file wrong");
    chk_special_wr: assert property (@(posedge i_clk) disable iff (i_reset)
        exe && i_instr[13:6] == 8'h00 && i_instr[5:0] != 6'h00
        |=> swe_reg && sa_reg == $past(i_instr[5:0])
        && fw_reg == $past(acc_reg))
        else $error("store to special register wrong");
    chk_nop_idle: assert property (@(posedge i_clk) disable iff (i_reset)
        exe && i_instr == 14'h0000 |=> $stable(acc_reg) && !fwe_reg
        && !swe_reg && pc_reg == $past(pc_reg) + 12'h001)
        else $error("no-op had an effect");
    chk_ret_two: assert property (@(posedge i_clk) disable iff (i_reset)
        exe && i_instr == 14'h0040 |=> flush_reg && hold_reg
        && sp_reg == $past(sp_reg) - 3'h1 ##1 $stable(pc_reg))
        else $error("return timing wrong");
    chk_ret_target: assert property (@(posedge i_clk) disable iff (i_reset)
        exe && i_instr == 14'h0040 |=> pc_reg == $past(top_entry))
        else $error("return target wrong");
    chk_interrupt_return_target: assert property (@(posedge i_clk) disable iff (i_reset)
        exe && i_instr == 14'h0060 |=> pc_reg == $past(top_entry))
        else $error("interrupt return target wrong");
    chk_call_push: assert property (@(posedge i_clk) disable iff (i_reset)
        exe && i_instr[13:12] == 2'h2 |=> sp_reg == $past(sp_reg) + 3'h1
        && pc_reg == $past(i_instr[11:0]))
        else $error("call push wrong");
endmodule
`default_nettype wire

// >>> verif/cise_mem_model.sv
// Program memory and file register model facing the execute core
`timescale 1ns/1ps
`default_nettype none
module cise_mem_model (
    input wire logic i_clk,
    input wire logic [11:0] i_program_counter,
    input wire logic [6:0] i_file_raddr,
    input wire logic [6:0] i_file_addr,
    input wire logic [7:0] i_file_wdata,
    input wire logic i_file_we,
    output logic [13:0] o_instr,
    output logic [7:0] o_file_rdata
);
    logic [13:0] prog [0:4095];
    logic [7:0] file_mem [0:127];
    // Asynchronous reads, as the core expects a same-cycle answer
    assign o_instr = prog[i_program_counter];
    assign o_file_rdata = file_mem[i_file_raddr];
    // Plain always: the bench also preloads this array
    always @(posedge i_clk) begin
        if (i_file_we) begin
            file_mem[i_file_addr] <= i_file_wdata;
        end
    end
endmodule
`default_nettype wire

// >>> verif/test_cise_core.sv
// Self-checking bench for the instruction subset execute core
`timescale 1ns/1ps
`default_nettype none
module test_cise_core;
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic [13:0] instr;
    logic [7:0] rdata;
    logic [11:0] pc;
    logic [6:0] faddr;
    logic [7:0] fwdata;
    logic fwe;
    logic [5:0] saddr;
    logic [7:0] swdata;
    logic swe;
    logic [7:0] acc;
    logic zero;
    logic global_irq_enable;
    int error_cnt = 0;
    int n_tests = 0;
    logic [13:0] q[$];
    always #12.5 i_clk = ~i_clk;
    cise_core cise_core_inst (.i_clk(i_clk), .i_reset(i_reset),
        .i_instr(instr), .i_file_rdata(rdata), .o_program_counter(pc),
        .o_file_addr(faddr), .o_file_wdata(fwdata), .o_file_we(fwe),
        .o_special_addr(saddr), .o_special_wdata(swdata),
        .o_special_we(swe), .o_acc(acc), .o_zero_flag(zero),
        .o_global_irq_enable(global_irq_enable));
    cise_mem_model cise_mem_model_inst (.i_clk(i_clk),
        .i_program_counter(pc), .i_file_raddr(instr[6:0]),
        .i_file_addr(faddr), .i_file_wdata(fwdata), .i_file_we(fwe),
        .o_instr(instr), .o_file_rdata(rdata));
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    task automatic load(input logic [11:0] base);
        for (int a = 0; a < q.size(); a++) begin
            cise_mem_model_inst.prog[base + a] = q[a];
        end
    endtask
    task automatic start;
        i_reset = 1'b1;
        step(3);
        i_reset = 1'b0;
    endtask
    // Gaps keep a read from racing the write-back of the line before
    task automatic arith_case;
        q = '{14'h1901, 14'h0090, 14'h0000, 14'h0390, 14'h0000, 14'h0a10,
              14'h19ff, 14'h0091, 14'h0000, 14'h0a91, 14'h0000, 14'h0311};
        load(12'h000);
        start();
        step(4);
        chk(zero, 1'b1);
        step(2);
        chk(acc, 8'h01);
        chk(zero, 1'b0);
        chk(cise_mem_model_inst.file_mem[16], 8'h00);
        step(4);
        chk(zero, 1'b1);
        step(2);
        chk(acc, 8'hff);
        chk(cise_mem_model_inst.file_mem[17], 8'h00);
    endtask
    task automatic skip_case;
        q = '{14'h1902, 14'h0090, 14'h0000, 14'h0b90, 14'h1955, 14'h0b10,
              14'h1977, 14'h0000, 14'h19ff, 14'h0091, 14'h0000, 14'h0f91,
              14'h1911, 14'h0000};
        load(12'h000);
        start();
        step(5);
        chk(acc, 8'h55);
        step(3);
        chk(acc, 8'h00);
        chk(zero, 1'b0);
        step(6);
        chk(acc, 8'hff);
        chk(zero, 1'b0);
        chk(cise_mem_model_inst.file_mem[17], 8'h00);
    endtask
    task automatic or_case;
        q = '{14'h1991, 14'h0413, 14'h1a35, 14'h1900, 14'h1a00, 14'h1955,
              14'h0493, 14'h0000, 14'h0813, 14'h003f};
        load(12'h000);
        cise_mem_model_inst.file_mem[19] = 8'h13;
        start();
        step(2);
        chk(acc, 8'h93);
        step(1);
        chk(acc, 8'hb7);
        step(2);
        chk(zero, 1'b1);
        step(1);
        chk(zero, 1'b1);
        step(1);
        chk({fwe, faddr}, 8'h93);
        chk(fwdata, 8'h57);
        chk(acc, 8'h55);
        step(2);
        chk(acc, 8'h57);
        step(1);
        chk({swe, saddr}, 7'h7f);
        chk(swdata, 8'h57);
    endtask
    task automatic flow_case;
        q = '{14'h2100, 14'h1922, 14'h3050, 14'h1933};
        load(12'h000);
        q = '{14'h0000, 14'h2060, 14'h1944, 14'h3053};
        load(12'h050);
        q = '{14'h0000, 14'h0060};
        load(12'h060);
        q = '{14'h0040};
        load(12'h100);
        start();
        step(1);
        chk(pc, 12'h100);
        step(5);
        chk(acc, 8'h22);
        chk(global_irq_enable, 1'b0);
        step(1);
        chk(pc, 12'h050);
        step(13);
        chk(acc, 8'h44);
        chk(global_irq_enable, 1'b1);
    endtask
    task automatic complete_run;
        $display("Comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        for (int a = 0; a < 4096; a++) begin
            cise_mem_model_inst.prog[a] = 14'h0000;
        end
        for (int a = 0; a < 128; a++) begin
            cise_mem_model_inst.file_mem[a] = 8'h00;
        end
        arith_case();
        skip_case();
        or_case();
        flow_case();
        complete_run();
    end
endmodule
`default_nettype wire
